/* File: pkg/bsac_cfg.svh */
// Constants for the cascaded ALU slice: widths, fields, reset values
`ifndef BSAC_CFG_SVH
`define BSAC_CFG_SVH

// Slice data width and register file depth
`define BSAC_SLICE_W     4
`define BSAC_RAM_DEPTH   16
// Instruction word width and field positions
`define BSAC_INSTR_W     9
`define BSAC_SRC_BIT     0
`define BSAC_FN_LO       1
`define BSAC_FN_HI       4
`define BSAC_DST_LO      5
`define BSAC_DST_HI      8
// Low instruction field value that selects special-function mode
`define BSAC_SPECIAL_CODE 5'h00
// Reset values of the clocked state
`define BSAC_Q_RST       4'h0
`define BSAC_SIGN_RST    1'h0
`define BSAC_RAM_RST     4'h0

`endif

/* File: pkg/bsac_pkg.sv */
// Types for the cascaded ALU slice
package bsac_pkg;
	// ALU function codes
	typedef enum logic [3:0] {
		BSAC_FN_ZERO  = 4'h0, BSAC_FN_SMR   = 4'h1,
		BSAC_FN_RMS   = 4'h2, BSAC_FN_ADD   = 4'h3,
		BSAC_FN_S     = 4'h4, BSAC_FN_NS    = 4'h5,
		BSAC_FN_R     = 4'h6, BSAC_FN_NR    = 4'h7,
		BSAC_FN_CLR   = 4'h8, BSAC_FN_NRAS  = 4'h9,
		BSAC_FN_XNOR  = 4'ha, BSAC_FN_XOR   = 4'hb,
		BSAC_FN_AND   = 4'hc, BSAC_FN_NOR   = 4'hd,
		BSAC_FN_NAND  = 4'he, BSAC_FN_OR    = 4'hf
	} bsac_fn_e;
	// Destination and shift codes in normal mode
	typedef enum logic [3:0] {
		BSAC_DST_RAM_DN  = 4'h0, BSAC_DST_RAMQ_DN = 4'h1,
		BSAC_DST_RAM_UP  = 4'h2, BSAC_DST_RAMQ_UP = 4'h3,
		BSAC_DST_RAM     = 4'h4, BSAC_DST_RAM_QF  = 4'h5,
		BSAC_DST_NONE    = 4'h6, BSAC_DST_QF      = 4'h7,
		BSAC_DST_Q_DN    = 4'h8, BSAC_DST_Q_UP    = 4'h9
	} bsac_dst_e;
	// Special-function codes
	typedef enum logic [3:0] {
		BSAC_SPC_NORM = 4'h0,
		BSAC_SPC_INC  = 4'h1
	} bsac_spc_e;
endpackage : bsac_pkg

/* File: pkg/bsac_ram_if.sv */
// Register file access bundle between slice core and storage
`timescale 1ns/100ps
`include "bsac_cfg.svh"
interface bsac_ram_if;
	logic [3:0]               addr_a;  // Read port A address
	logic [3:0]               addr_b;  // Read port B address
	logic [`BSAC_SLICE_W-1:0] rd_a;    // Port A data
	logic [`BSAC_SLICE_W-1:0] rd_b;    // Port B data
	logic                     wr_en;   // Write this cycle
	logic [3:0]               wr_addr; // Write address
	logic [`BSAC_SLICE_W-1:0] wr_data; // Write data
	// Core side
	modport ctrl (output addr_a, addr_b, wr_en, wr_addr, wr_data,
		input rd_a, rd_b);
	// Storage side
	modport mem (input addr_a, addr_b, wr_en, wr_addr, wr_data,
		output rd_a, rd_b);
endinterface : bsac_ram_if

/* File: design/bsac_ram.sv */
// Sixteen-word register file in flip-flops, two reads, one write
`timescale 1ns/100ps
`include "bsac_cfg.svh"
module bsac_ram #(
	parameter int DEPTH = `BSAC_RAM_DEPTH
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Access bundle
	bsac_ram_if.mem  ram
);
	logic [`BSAC_SLICE_W-1:0] mem_r [DEPTH]; // Storage words

	// Write closes the low phase of the cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= `BSAC_RAM_RST;
			end
		end else if (ram.wr_en) begin
			mem_r[ram.wr_addr] <= ram.wr_data;
		end
	end

	// Asynchronous reads
	assign ram.rd_a = mem_r[ram.addr_a];
	assign ram.rd_b = mem_r[ram.addr_b];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ram_store: assert property (
		ram.wr_en |=> mem_r[$past(ram.wr_addr)] == $past(ram.wr_data))
		else $error("RAM word not stored on write strobe");
	a_ram_hold: assert property (
		!ram.wr_en |=> mem_r[$past(ram.addr_b)] == $past(ram.rd_b))
		else $error("RAM word changed without write strobe");
endmodule : bsac_ram

/* File: design/bsac_alu.sv */
// Combinational slice ALU with carry generate, propagate, overflow
`timescale 1ns/100ps
`include "bsac_cfg.svh"
module bsac_alu #(
	parameter int W = `BSAC_SLICE_W
) (
	// Operands and function
	input  wire logic [W-1:0] r,
	input  wire logic [W-1:0] s,
	input  wire logic         cin,
	input  wire logic [3:0]   fn,
	// Results
	output logic      [W-1:0] f,
	output logic              cout,
	output logic              gen,
	output logic              prop,
	output logic              overflow_flag
);
	// Sum with carry out on top
	function automatic logic [W:0] add_c(input logic [W-1:0] a,
		input logic [W-1:0] b, input logic c);
		add_c = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, c};
	endfunction : add_c

	logic [W-1:0] op_a;  // First adder operand
	logic [W-1:0] op_b;  // Second adder operand
	logic         arith; // Function uses the adder
	logic [W:0]   sum;   // Adder result

	// Operand steering and logic functions
	always_comb begin
		op_a  = r;
		op_b  = s;
		arith = 1'b1;
		f     = '0;
		unique case (bsac_pkg::bsac_fn_e'(fn))
			bsac_pkg::BSAC_FN_ZERO: op_a = '0;
			bsac_pkg::BSAC_FN_SMR:  op_a = ~r;
			bsac_pkg::BSAC_FN_RMS:  op_b = ~s;
			bsac_pkg::BSAC_FN_ADD:  op_a = r;
			bsac_pkg::BSAC_FN_S:    op_a = '0;
			bsac_pkg::BSAC_FN_NS:   begin op_a = '0; op_b = ~s; end
			bsac_pkg::BSAC_FN_R:    op_b = '0;
			bsac_pkg::BSAC_FN_NR:   begin op_a = ~r; op_b = '0; end
			default:                arith = 1'b0;
		endcase
		sum = add_c(op_a, op_b, cin);
		// Logic codes overwrite the sum
		unique case (bsac_pkg::bsac_fn_e'(fn))
			bsac_pkg::BSAC_FN_CLR:  f = '0;
			bsac_pkg::BSAC_FN_NRAS: f = ~r & s;
			bsac_pkg::BSAC_FN_XNOR: f = ~(r ^ s);
			bsac_pkg::BSAC_FN_XOR:  f = r ^ s;
			bsac_pkg::BSAC_FN_AND:  f = r & s;
			bsac_pkg::BSAC_FN_NOR:  f = ~(r | s);
			bsac_pkg::BSAC_FN_NAND: f = ~(r & s);
			bsac_pkg::BSAC_FN_OR:   f = r | s;
			default:                f = sum[W-1:0];
		endcase
	end

	// Lookahead terms across the slice
	always_comb begin
		gen  = 1'b0;
		prop = 1'b1;
		for (int i = 0; i < W; i++) begin
			gen  = (op_a[i] & op_b[i]) | (gen & (op_a[i] | op_b[i]));
			prop = prop & (op_a[i] | op_b[i]);
		end
		gen  = gen & arith;
		prop = prop & arith;
	end

	assign cout = arith & sum[W];
	// Signed overflow from the top bit
	assign overflow_flag  = arith & (op_a[W-1] == op_b[W-1]) &
		(sum[W-1] != op_a[W-1]);
endmodule : bsac_alu

/* File: design/bsac_slice.sv */
// Four-bit ALU slice: cascade pins, position straps, Q and RAM control
//
// Notes on behaviour
// - Low output enable drives shifter result out.
// - Q and sign flop move on rising edge.
// - RAM writes on the rising edge that ends the low phase, when strobed.
// - Upper shift pins chain to next slice's lower.
// - Low select tied low: write pin drives strobe.
// - Intermediate slice: both strap pins high.
// - Top slice: select high, write pin low.
// - Open-collector zero line shared by all slices.
// - Top slice gives sign, overflow; others generate, propagate.
// - Gate high suppresses Q and sign flop updates, not RAM writes.
// - Gate controls RAM only via own write output.
// - Slices chain to any width in 4-bit steps.
// - Zero low instruction field selects special mode.
`timescale 1ns/100ps
`include "bsac_cfg.svh"
module bsac_slice #(
	parameter int W     = `BSAC_SLICE_W,
	parameter int DEPTH = `BSAC_RAM_DEPTH
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rst,
	// Microinstruction from the pipeline register
	input  wire logic [`BSAC_INSTR_W-1:0] instr,
	input  wire logic [3:0]               a_addr,
	input  wire logic [3:0]               b_addr,
	input  wire logic [W-1:0]             d_in,
	input  wire logic                     instruction_gate_low,
	input  wire logic                     write_en_low,
	input  wire logic                     result_oe_low,
	// Result lines
	output logic      [W-1:0]             y_out,
	output logic                          y_oe,
	// Position straps
	input  wire logic                     low_slice_select,
	input  wire logic                     write_or_top_slice_in,
	output logic                          write_or_top_slice_out,
	output logic                          write_or_top_slice_oe,
	// ALU shift pins
	input  wire logic                     alu_shift_low_in,
	output logic                          alu_shift_low_out,
	output logic                          alu_shift_low_oe,
	input  wire logic                     alu_shift_high_in,
	output logic                          alu_shift_high_out,
	output logic                          alu_shift_high_oe,
	// Q register shift pins
	input  wire logic                     qreg_shift_low_in,
	output logic                          qreg_shift_low_out,
	output logic                          qreg_shift_low_oe,
	input  wire logic                     qreg_shift_high_in,
	output logic                          qreg_shift_high_out,
	output logic                          qreg_shift_high_oe,
	// Carry chain and flag pins
	input  wire logic                     carry_in,
	output logic                          carry_out,
	output logic                          gen_or_sign,
	output logic                          prop_or_ovr,
	// Shared open-collector zero line
	input  wire logic                     zero_in,
	output logic                          zero_out,
	output logic                          zero_oe,
	// Status
	output logic                          word_zero,
	output logic                          sign_compare,
	output logic      [W-1:0]             q_value
);
	// Decoded instruction
	logic                  special;   // Special-function mode
	logic                  src_dq;    // Operands from D and Q
	logic [3:0]            fn_code;   // ALU function field
	logic [3:0]            dst_code;  // Destination field
	logic                  is_top;    // Strapped as top slice
	logic                  gate_on;   // Instruction enabled
	// Datapath
	logic [W-1:0]          q_r;       // Q register
	logic [W-1:0]          q_nxt;     // Q next value
	logic                  q_load;    // Q takes q_nxt
	logic                  sign_r;    // Sign compare flop
	logic [W-1:0]          alu_r;     // ALU R operand
	logic [W-1:0]          alu_s;     // ALU S operand
	logic [3:0]            alu_fn;    // Function to the ALU
	logic [W-1:0]          f;         // ALU result
	logic                  gen;       // Carry generate
	logic                  prop;      // Carry propagate
	logic                  overflow_flag;       // Signed overflow
	logic [W-1:0]          shift_f;   // Shifter output
	logic [W-1:0]          zero_src;  // Word tested for zero
	// Shift and write decode
	logic                  ram_dest;  // Destination writes RAM
	logic                  ram_up;    // RAM path shifts up
	logic                  ram_dn;    // RAM path shifts down
	logic                  q_up;      // Q shifts up
	logic                  q_dn;      // Q shifts down
	logic                  q_f;       // Q loads F

	bsac_ram_if ram_bus ();

	// Field split
	assign special  = instr[`BSAC_FN_HI:`BSAC_SRC_BIT] ==
		`BSAC_SPECIAL_CODE;
	assign src_dq   = instr[`BSAC_SRC_BIT];
	assign fn_code  = instr[`BSAC_FN_HI:`BSAC_FN_LO];
	assign dst_code = instr[`BSAC_DST_HI:`BSAC_DST_LO];
	assign gate_on  = ~instruction_gate_low;

	// Position from straps: top slice has select high, write pin low
	assign is_top = low_slice_select & ~write_or_top_slice_in;

	// Destination decode, normal and special
	always_comb begin
		ram_dest = 1'b0;
		ram_up   = 1'b0;
		ram_dn   = 1'b0;
		q_up     = 1'b0;
		q_dn     = 1'b0;
		q_f      = 1'b0;
		if (special) begin
			// Upper field code 0 adds Q shift up; RAM always written from B
			ram_dest = 1'b1;
			q_up = dst_code == bsac_pkg::BSAC_SPC_NORM;
		end else begin
			unique case (bsac_pkg::bsac_dst_e'(dst_code))
				bsac_pkg::BSAC_DST_RAM_DN: begin
					ram_dest = 1'b1;
					ram_dn   = 1'b1;
				end
				bsac_pkg::BSAC_DST_RAMQ_DN: begin
					ram_dest = 1'b1;
					ram_dn   = 1'b1;
					q_dn     = 1'b1;
				end
				bsac_pkg::BSAC_DST_RAM_UP: begin
					ram_dest = 1'b1;
					ram_up   = 1'b1;
				end
				bsac_pkg::BSAC_DST_RAMQ_UP: begin
					ram_dest = 1'b1;
					ram_up   = 1'b1;
					q_up     = 1'b1;
				end
				bsac_pkg::BSAC_DST_RAM:    ram_dest = 1'b1;
				bsac_pkg::BSAC_DST_RAM_QF: begin
					ram_dest = 1'b1;
					q_f      = 1'b1;
				end
				bsac_pkg::BSAC_DST_NONE:   ram_dest = 1'b0;
				bsac_pkg::BSAC_DST_QF:     q_f = 1'b1;
				bsac_pkg::BSAC_DST_Q_DN:   q_dn = 1'b1;
				bsac_pkg::BSAC_DST_Q_UP:   q_up = 1'b1;
				// Unused codes write RAM unshifted
				default:                   ram_dest = 1'b1;
			endcase
		end
	end

	// Operand selection; special mode adds carry to B
	always_comb begin
		if (special) begin
			alu_r  = '0;
			alu_s  = ram_bus.rd_b;
			alu_fn = bsac_pkg::BSAC_FN_S;
		end else begin
			alu_r  = src_dq ? d_in : ram_bus.rd_a;
			alu_s  = src_dq ? q_r  : ram_bus.rd_b;
			alu_fn = fn_code;
		end
	end

	bsac_alu #(
		.W    (W)
	) u_alu (
		.r    (alu_r),
		.s    (alu_s),
		.cin  (carry_in),
		.fn   (alu_fn),
		.f    (f),
		.cout (carry_out),
		.gen  (gen),
		.prop (prop),
		.overflow_flag  (overflow_flag)
	);

	// Shifter: bits cross to neighbour slices through the pins
	always_comb begin
		if (ram_up) begin
			shift_f = {f[W-2:0], alu_shift_low_in};
		end else if (ram_dn) begin
			shift_f = {alu_shift_high_in, f[W-1:1]};
		end else begin
			shift_f = f;
		end
	end

	// ALU shift pins drive only toward the neighbour receiving the bit
	assign alu_shift_high_oe  = ram_up;
	assign alu_shift_high_out = f[W-1];
	assign alu_shift_low_oe   = ram_dn;
	assign alu_shift_low_out  = f[0];

	// Q shift pins, same direction scheme
	assign qreg_shift_high_oe  = q_up;
	assign qreg_shift_high_out = q_r[W-1];
	assign qreg_shift_low_oe   = q_dn;
	assign qreg_shift_low_out  = q_r[0];

	// Q next value
	always_comb begin
		if (q_up) begin
			q_nxt = {q_r[W-2:0], qreg_shift_low_in};
		end else if (q_dn) begin
			q_nxt = {qreg_shift_high_in, q_r[W-1:1]};
		end else begin
			q_nxt = f;
		end
	end
	assign q_load = gate_on & (q_up | q_dn | q_f);

	// Q register on the rising edge, held while the gate is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q_r <= `BSAC_Q_RST;
		end else if (q_load) begin
			q_r <= q_nxt;
		end
	end

	// Sign compare flop: operand sign against result sign
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sign_r <= `BSAC_SIGN_RST;
		end else if (gate_on) begin
			sign_r <= alu_r[W-1] ^ f[W-1];
		end
	end

	// Register file: write only on the strobe input, gate acts via
	// the write output when the strobe is wired from it
	assign ram_bus.addr_a  = a_addr;
	assign ram_bus.addr_b  = b_addr;
	assign ram_bus.wr_addr = b_addr;
	assign ram_bus.wr_data = shift_f;
	assign ram_bus.wr_en   = ~write_en_low;

	bsac_ram #(
		.DEPTH   (DEPTH)
	) u_ram (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ram     (ram_bus.mem)
	);

	// Low slice drives the shared write strobe; others only listen
	assign write_or_top_slice_oe  = ~low_slice_select;
	assign write_or_top_slice_out = ~(gate_on & ram_dest);

	// Result lines
	assign y_oe  = ~result_oe_low;
	assign y_out = shift_f;

	// Zero line: pull low while the tested word is non-zero
	assign zero_src  = (special && q_up) ? q_r : f;
	assign zero_oe   = |zero_src;
	assign zero_out  = 1'b0;
	assign word_zero = zero_in;

	// Flag pins depend on slice position
	assign gen_or_sign = is_top ? f[W-1] : gen;
	assign prop_or_ovr = is_top ? overflow_flag : prop;

	assign sign_compare = sign_r;
	assign q_value      = q_r;

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_result_drive: assert property (
		(!result_oe_low |-> y_oe && y_out == shift_f) and
		(result_oe_low |-> !y_oe))
		else $error("Result enable does not match drive");
	a_q_gated: assert property (
		instruction_gate_low |=> q_r == $past(q_r))
		else $error("Q changed with gate high");
	a_q_loads_f: assert property (
		gate_on && q_f && !q_up && !q_dn |=> q_r == $past(f))
		else $error("Q did not take ALU result");
	a_q_shift_up: assert property (
		gate_on && q_up ##1 1'b1 |->
		q_r == {$past(q_r[W-2:0]), $past(qreg_shift_low_in)})
		else $error("Q up shift wrong");
	a_write_strobe: assert property (
		!low_slice_select |-> write_or_top_slice_oe &&
		write_or_top_slice_out == !(gate_on && ram_dest))
		else $error("Low slice write output wrong");
	a_strap_listen: assert property (
		low_slice_select |-> !write_or_top_slice_oe)
		else $error("Non-low slice drives write pin");
	a_top_flags: assert property (
		is_top |-> gen_or_sign == f[W-1] && prop_or_ovr == overflow_flag)
		else $error("Top slice flag pins wrong");
	a_mid_flags: assert property (
		!is_top |-> gen_or_sign == gen && prop_or_ovr == prop)
		else $error("Lower slice flag pins wrong");
	a_zero_pull: assert property (
		zero_oe == (zero_src != '0) && !zero_out)
		else $error("Zero line pull wrong");
	a_special_mode: assert property (
		instr[4:0] == 5'h00 |-> special && alu_s == ram_bus.rd_b)
		else $error("Special mode not entered");
	a_shift_pins: assert property (
		ram_up |-> alu_shift_high_oe && !alu_shift_low_oe &&
		alu_shift_high_out == f[W-1])
		else $error("ALU up shift pins wrong");

	c_special: cover property (special && gate_on ##1 !special);
	c_q_up: cover property (gate_on && q_up ##1 gate_on && q_up);
	c_low_write: cover property (!low_slice_select &&
		!write_or_top_slice_out);
	c_top_ovr: cover property (is_top && overflow_flag);
endmodule : bsac_slice

/* File: verif/bsac_partner.sv */
// Pipeline register and neighbour slices around one ALU slice
`timescale 1ns/100ps
module bsac_partner (
	// Clock and bench controls
	input  wire logic        clk_sys,
	input  wire logic [26:0] fetch,
	input  wire logic        we_self,
	input  wire logic        top_strap,
	// Microword towards the slice
	output logic      [8:0]  instr,
	output logic      [3:0]  a_addr,
	output logic      [3:0]  b_addr,
	output logic      [3:0]  d_in,
	output logic             instruction_gate_low,
	output logic             write_en_low,
	output logic             result_oe_low,
	output logic             carry_in,
	// Resolved shared pins
	output logic             alu_shift_low_in,
	output logic             alu_shift_high_in,
	output logic             qreg_shift_low_in,
	output logic             qreg_shift_high_in,
	output logic             write_or_top_slice_in,
	output logic             zero_in,
	// Slice drivers on shared pins
	input  wire logic        alu_shift_low_out,
	input  wire logic        alu_shift_low_oe,
	input  wire logic        alu_shift_high_out,
	input  wire logic        alu_shift_high_oe,
	input  wire logic        qreg_shift_low_out,
	input  wire logic        qreg_shift_low_oe,
	input  wire logic        qreg_shift_high_out,
	input  wire logic        qreg_shift_high_oe,
	input  wire logic        write_or_top_slice_out,
	input  wire logic        write_or_top_slice_oe,
	input  wire logic        zero_out,
	input  wire logic        zero_oe
);
	logic [26:0] pipe_r = 27'h0e00000; // Starts idle: gate off, no write

	// Same-edge pipeline register, one microword per cycle
	always @(posedge clk_sys) begin
		pipe_r <= fetch;
	end

	// Field split of the held microword
	assign instr                = pipe_r[8:0];
	assign a_addr               = pipe_r[12:9];
	assign b_addr               = pipe_r[16:13];
	assign d_in                 = pipe_r[20:17];
	assign instruction_gate_low = pipe_r[21];
	assign result_oe_low        = pipe_r[23];
	// Carry from the lower neighbour or lookahead unit
	assign carry_in             = pipe_r[24];
	// Neighbour reads the slice; else end multiplexer fills
	assign alu_shift_low_in   = alu_shift_low_oe ?
		alu_shift_low_out : pipe_r[25];
	assign alu_shift_high_in  = alu_shift_high_oe ?
		alu_shift_high_out : pipe_r[25];
	assign qreg_shift_low_in  = qreg_shift_low_oe ?
		qreg_shift_low_out : pipe_r[26];
	assign qreg_shift_high_in = qreg_shift_high_oe ?
		qreg_shift_high_out : pipe_r[26];
	// Strap level unless the slice drives its write pin
	assign write_or_top_slice_in = write_or_top_slice_oe ?
		write_or_top_slice_out : top_strap;
	// Strobe wired from own write pin, or from the microword
	assign write_en_low = we_self ?
		write_or_top_slice_in : pipe_r[22];
	// Pulled-up zero line, other slices released
	assign zero_in = ~(zero_oe & ~zero_out);
endmodule : bsac_partner

/* File: verif/tb.sv */
// Self-checking bench for the cascaded ALU slice
`timescale 1ns/100ps
module tb;
	localparam logic [26:0] IDLE = 27'h0e00000; // Gate off, no write
	// Microwords: D+Q to RAM, to Q, shifts; RAM A+B unstored
	localparam logic [8:0] LD_RAM = {bsac_pkg::BSAC_DST_RAM,
		bsac_pkg::BSAC_FN_ADD, 1'b1};
	localparam logic [8:0] LD_Q = {bsac_pkg::BSAC_DST_QF,
		bsac_pkg::BSAC_FN_ADD, 1'b1};
	localparam logic [8:0] RD = {bsac_pkg::BSAC_DST_NONE,
		bsac_pkg::BSAC_FN_ADD, 1'b0};
	localparam logic [8:0] UP = {bsac_pkg::BSAC_DST_RAM_UP,
		bsac_pkg::BSAC_FN_ADD, 1'b1};
	localparam logic [8:0] DN = {bsac_pkg::BSAC_DST_RAM_DN,
		bsac_pkg::BSAC_FN_ADD, 1'b1};
	localparam logic [8:0] QUP = {bsac_pkg::BSAC_DST_Q_UP,
		bsac_pkg::BSAC_FN_ADD, 1'b1};
	localparam logic [8:0] SPC = {bsac_pkg::BSAC_SPC_INC, 5'h00};
	logic        clk_sys, rst, we_self, top_strap, low_slice_select;
	logic [26:0] fetch;     // Next microword
	int          err_count; // Mismatches
	int          cmp_count; // Comparisons
	wire logic [8:0] instr;
	wire logic [3:0] a_addr, b_addr, d_in, y_out, q_value;
	wire logic instruction_gate_low, write_en_low, result_oe_low, y_oe;
	wire logic carry_in, carry_out, gen_or_sign, prop_or_ovr;
	wire logic write_or_top_slice_in, write_or_top_slice_out;
	wire logic write_or_top_slice_oe, zero_in, zero_out, zero_oe;
	wire logic alu_shift_low_in, alu_shift_low_out, alu_shift_low_oe;
	wire logic alu_shift_high_in, alu_shift_high_out, alu_shift_high_oe;
	wire logic qreg_shift_low_in, qreg_shift_low_out, qreg_shift_low_oe;
	wire logic qreg_shift_high_in, qreg_shift_high_out;
	wire logic qreg_shift_high_oe, word_zero, sign_compare;

	// Device under test
	bsac_slice uut (.clk_sys, .rst, .instr, .a_addr, .b_addr, .d_in,
		.instruction_gate_low, .write_en_low, .result_oe_low, .y_out,
		.y_oe, .low_slice_select, .write_or_top_slice_in,
		.write_or_top_slice_out, .write_or_top_slice_oe,
		.alu_shift_low_in, .alu_shift_low_out, .alu_shift_low_oe,
		.alu_shift_high_in, .alu_shift_high_out, .alu_shift_high_oe,
		.qreg_shift_low_in, .qreg_shift_low_out, .qreg_shift_low_oe,
		.qreg_shift_high_in, .qreg_shift_high_out, .qreg_shift_high_oe,
		.carry_in, .carry_out, .gen_or_sign, .prop_or_ovr, .zero_in,
		.zero_out, .zero_oe, .word_zero, .sign_compare, .q_value);
	// Pipeline register and neighbours
	bsac_partner far (.clk_sys, .fetch, .we_self, .top_strap, .instr,
		.a_addr, .b_addr, .d_in, .instruction_gate_low, .write_en_low,
		.result_oe_low, .carry_in, .alu_shift_low_in, .alu_shift_high_in,
		.qreg_shift_low_in, .qreg_shift_high_in, .write_or_top_slice_in,
		.zero_in, .alu_shift_low_out, .alu_shift_low_oe,
		.alu_shift_high_out, .alu_shift_high_oe, .qreg_shift_low_out,
		.qreg_shift_low_oe, .qreg_shift_high_out, .qreg_shift_high_oe,
		.write_or_top_slice_out, .write_or_top_slice_oe, .zero_out,
		.zero_oe);

	// 25 MHz clock
	always #20 clk_sys = ~clk_sys;

	// Counted comparison
	task automatic chk(input string nm, input logic [3:0] exp,
		input logic [3:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Fetch a microword, stop mid-cycle while it is applied
	task automatic run(input logic [8:0] ins, input logic [3:0] a, b, d,
		input logic gate, we_n, cin, fa, fq, oe_n);
		@(posedge clk_sys);
		fetch <= {fq, fa, cin, oe_n, we_n, gate, d, b, a, ins};
		@(posedge clk_sys);
		fetch <= IDLE;
		@(negedge clk_sys);
		#1;
	endtask : run
	// Let the applied microword execute
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick
	// Read a register word as RAM[n] plus the zero word 15
	task automatic peek(input logic [3:0] n, input logic [3:0] exp);
		run(RD, n, 4'hf, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("ram_word", exp, y_out);
	endtask : peek
	// Verdict
	task automatic end_of_test;
		$display("Comparisons %0d, errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	// Hang guard
	initial begin
		repeat (2000) @(posedge clk_sys);
		err_count++;
		end_of_test();
	end

	// Main sequence
	initial begin
		err_count = 0;
		cmp_count = 0;
		clk_sys = 1'b0;
		rst = 1'b1;
		fetch = IDLE;
		we_self = 1'b0;
		top_strap = 1'b1;
		low_slice_select = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		chk("q_value", 4'h0, q_value);
		peek(4'h3, 4'h0);
		// Strobed write, strobe high, gate high with strobe low
		run(LD_RAM, 4'h0, 4'h3, 4'h9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("y_out", 4'h9, y_out);
		chk("y_oe", 4'h1, y_oe);
		chk("wr_oe", 4'h0, write_or_top_slice_oe);
		peek(4'h3, 4'h9);
		run(LD_RAM, 4'h0, 4'h3, 4'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		chk("y_oe", 4'h0, y_oe);
		peek(4'h3, 4'h9);
		run(LD_RAM, 4'h0, 4'h4, 4'h6, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("wr_out", 4'h1, write_or_top_slice_out);
		peek(4'h4, 4'h6);
		// Low slice with strobe from its own write pin
		@(posedge clk_sys);
		low_slice_select <= 1'b0;
		we_self <= 1'b1;
		run(LD_RAM, 4'h0, 4'h5, 4'h7, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("wr_oe", 4'h1, write_or_top_slice_oe);
		peek(4'h5, 4'h0);
		run(LD_RAM, 4'h0, 4'h5, 4'h7, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("wr_out", 4'h0, write_or_top_slice_out);
		peek(4'h5, 4'h7);
		@(posedge clk_sys);
		low_slice_select <= 1'b1;
		we_self <= 1'b0;
		// Q: rising edge only, frozen by gate; sign flop after the edge
		run(LD_Q, 4'h0, 4'h0, 4'h7, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("zero_oe", 4'h1, zero_oe);
		chk("word_zero", 4'h0, word_zero);
		chk("zero_out", 4'h0, zero_out);
		chk("q_value", 4'h0, q_value);
		tick;
		chk("q_value", 4'h8, q_value);
		chk("sign_compare", 4'h1, sign_compare);
		run(LD_Q, 4'h0, 4'h0, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		tick;
		chk("q_value", 4'h8, q_value);
		run(LD_Q, 4'h0, 4'h0, 4'h7, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("zero_oe", 4'h0, zero_oe);
		chk("word_zero", 4'h1, word_zero);
		tick;
		chk("sign_compare", 4'h0, sign_compare);
		// Flag pins of top and intermediate slices
		@(posedge clk_sys);
		top_strap <= 1'b0;
		run(LD_Q, 4'h0, 4'h0, 4'h7, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("sign", 4'h1, gen_or_sign);
		chk("ovr", 4'h1, prop_or_ovr);
		@(posedge clk_sys);
		top_strap <= 1'b1;
		run(LD_Q, 4'h0, 4'h0, 4'h7, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("gen", 4'h0, gen_or_sign);
		chk("prop", 4'h0, prop_or_ovr);
		run(LD_Q, 4'h0, 4'h0, 4'hf, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("carry_out", 4'h1, carry_out);
		chk("prop", 4'h1, prop_or_ovr);
		// Shifts with end fill
		run(UP, 4'h0, 4'h6, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		chk("alu_hi_oe", 4'h1, alu_shift_high_oe);
		chk("alu_hi_out", 4'h1, alu_shift_high_out);
		chk("alu_lo_oe", 4'h0, alu_shift_low_oe);
		peek(4'h6, 4'h3);
		run(DN, 4'h0, 4'h7, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		chk("alu_lo_out", 4'h1, alu_shift_low_out);
		chk("alu_hi_oe", 4'h0, alu_shift_high_oe);
		peek(4'h7, 4'hc);
		run(LD_Q, 4'h0, 4'h0, 4'h5, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		run(QUP, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		chk("q_hi_oe", 4'h1, qreg_shift_high_oe);
		chk("q_hi_out", 4'h0, qreg_shift_high_out);
		tick;
		chk("q_value", 4'hb, q_value);
		// Q down shift, a logic function, special normalize
		run({bsac_pkg::BSAC_DST_Q_DN, bsac_pkg::BSAC_FN_ADD, 1'b1}, 4'h0,
			4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("q_lo_oe", 4'h1, qreg_shift_low_oe);
		chk("q_lo_out", 4'h1, qreg_shift_low_out);
		tick;
		chk("q_value", 4'h5, q_value);
		run({bsac_pkg::BSAC_DST_NONE, bsac_pkg::BSAC_FN_XOR, 1'b1}, 4'h0,
			4'h0, 4'h6, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		chk("y_out", 4'h3, y_out);
		chk("carry_out", 4'h0, carry_out);
		run(9'h000, 4'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk("zero_oe", 4'h1, zero_oe);
		tick;
		chk("q_value", 4'ha, q_value);
		// Special mode increments word B
		run(SPC, 4'h0, 4'h3, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		peek(4'h3, 4'ha);
		// Second reset mid-run
		@(posedge clk_sys);
		rst <= 1'b1;
		@(posedge clk_sys);
		rst <= 1'b0;
		tick;
		chk("q_value", 4'h0, q_value);
		peek(4'h3, 4'h0);
		end_of_test();
	end
endmodule : tb
